//--- src/pbc_params.svh
// Functional notes
// - mask register zero at power-on, kept otherwise
// - mask bit one enables, zero blocks
// - mask bit1 powerdown, bit0 return normal
// - mask bits 31..2 read zero, write zero
// - clock stop register zero at power-on only
// - clock register write needs key byte a5
// - bit1 stops pci clock from pin
// - bit0 stops local bus clock
// - shared pin: bit0 also stops feedback clock
// - clock register unused bits read zero
// - hand bus back after each <=32 byte burst
// - memory controller acts as slave, mirrored registers
// - master flag bit30 always reads slave
// - control two/three: 16 bits, longword only
// - only sram, dram, sdram, muxed memory allowed
// - width 32 or 16; sdram 32 only
// - software never targets rom, byte sram, card
// - no ras-down mode offered
// - main controller does sdram setup and refresh
// - local side either endian, pci little
// - controller registers kept across software reset
// - events set status; write one clears
`ifndef PBC_PARAMS_SVH
`define PBC_PARAMS_SVH
`define PBC_OFF_MASK 8'h00
`define PBC_OFF_STAT 8'h04
`define PBC_OFF_CLK 8'h08
`define PBC_OFF_BCR1 8'h0c
`define PBC_OFF_BCR2 8'h10
`define PBC_OFF_BCR3 8'h14
`define PBC_OFF_AREA 8'h18
`define PBC_OFF_HSTAT 8'h40
`define PBC_WIN_TOP 8'h1c
`define PBC_CLK_KEY 8'ha5
`define PBC_KEY_HI 31
`define PBC_KEY_LO 24
`define PBC_BIT_PCI_HALT 1
`define PBC_BIT_LOC_HALT 0
`define PBC_BIT_PD 1
`define PBC_BIT_WAKE 0
`define PBC_BIT_MASTER 30
`define PBC_AREA_TYPE_HI 2
`define PBC_AREA_TYPE_LO 0
`define PBC_AREA_WID_HI 4
`define PBC_AREA_WID_LO 3
`define PBC_AREA_RAS 5
`define PBC_AREA_BIG 6
`define PBC_AREA_BITS 7
`define PBC_RST_WORD 32'h00000000
`define PBC_BURST_MAX 7'h20
`endif

//--- src/pbc_pkg.sv
package pbc_pkg;
    typedef enum logic [2:0]
    {
        PBC_MEM_SRAM = 3'h0,
        PBC_MEM_DRAM = 3'h1,
        PBC_MEM_SDRAM = 3'h2,
        PBC_MEM_MUXED = 3'h3,
        PBC_MEM_BROM = 3'h4,
        PBC_MEM_BCSRAM = 3'h5,
        PBC_MEM_CARD = 3'h6,
        PBC_MEM_NONE = 3'h7
    } pbc_mem_e;
    typedef enum logic [1:0]
    {
        PBC_WID_8 = 2'h0,
        PBC_WID_16 = 2'h1,
        PBC_WID_32 = 2'h2,
        PBC_WID_RSV = 2'h3
    } pbc_wid_e;
    typedef enum logic [1:0]
    {
        PBC_BS_IDLE = 2'h0,
        PBC_BS_REQ = 2'h1,
        PBC_BS_MOVE = 2'h2,
        PBC_BS_REL = 2'h3
    } pbc_burst_e;
    typedef enum logic [1:0]
    {
        PBC_HS_IDLE = 2'h0,
        PBC_HS_WAIT = 2'h1,
        PBC_HS_DONE = 2'h2
    } pbc_host_e;
endpackage

//--- src/pbc_if.sv
`timescale 1ns/1ps
`default_nettype none
// request held by the controller end until ack or err
interface pbc_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic [31:0] rdata;
    logic ack;
    logic err;
    modport dev(input req, input we, input addr, input wdata, input be, output rdata, output ack, output err);
    modport ctl(output req, output we, output addr, output wdata, output be, input rdata, input ack, input err);
endinterface
`default_nettype wire

//--- src/pbc_dev.sv
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pbc_params.svh"
module pbc_dev
(
    input wire logic clock,
    input wire logic rst,
    pbc_if.dev bus,
    input wire logic soft_reset,
    input wire logic powerdown_req_pin,
    input wire logic wake_normal_pin,
    input wire logic pci_clk_from_pin,
    input wire logic xfer_start,
    input wire logic [5:0] xfer_bytes,
    input wire logic [31:0] xfer_data,
    input wire logic bus_grant,
    output logic irq,
    output logic pci_clock_halt,
    output logic local_clock_halt,
    output logic feedback_clock_halt,
    output logic bus_req,
    output logic beat_valid,
    output logic [31:0] local_data,
    output logic xfer_done
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [1:0] mask_r, mask_nxt;
    logic [1:0] stat_r, stat_nxt;
    logic [1:0] clk_r, clk_nxt;
    logic [31:0] bcr1_r, bcr1_nxt;
    logic [15:0] bcr2_r, bcr2_nxt;
    logic [15:0] bcr3_r, bcr3_nxt;
    logic [`PBC_AREA_BITS-1:0] area_r, area_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic ack_r, ack_nxt;
    logic err_r, err_nxt;
    logic irq_r, irq_nxt;
    logic pch_r, pch_nxt;
    logic lch_r, lch_nxt;
    logic fbh_r, fbh_nxt;
    logic [2:0] pd_s_r, wk_s_r;
    logic [1:0] src_s_r; // level only, no edge history needed
    pbc_pkg::pbc_burst_e bs_r, bs_nxt;
    logic [4:0] beats_r, beats_nxt;
    logic breq_r, breq_nxt;
    logic bval_r, bval_nxt;
    logic [31:0] ldata_r, ldata_nxt;
    logic done_r, done_nxt;
    logic acc, wr, full_be;
    logic [6:0] cap_bytes;
    logic [6:0] beat_calc;

    // legal pci-transfer area: type, width, ras-down off
    function automatic logic area_ok(input logic [31:0] v);
        logic [2:0] t;
        logic [1:0] w;
        logic ok_t, ok_w;
        t = v[`PBC_AREA_TYPE_HI:`PBC_AREA_TYPE_LO];
        w = v[`PBC_AREA_WID_HI:`PBC_AREA_WID_LO];
        ok_t = (t == pbc_pkg::PBC_MEM_SRAM) || (t == pbc_pkg::PBC_MEM_DRAM) ||
               (t == pbc_pkg::PBC_MEM_SDRAM) || (t == pbc_pkg::PBC_MEM_MUXED);
        ok_w = (w == pbc_pkg::PBC_WID_32) ||
               ((w == pbc_pkg::PBC_WID_16) && (t != pbc_pkg::PBC_MEM_SDRAM));
        area_ok = ok_t && ok_w && !v[`PBC_AREA_RAS];
    endfunction

    // byte order onto the local side; pci side stays little endian
    function automatic logic [31:0] to_local(input logic [31:0] d, input logic big, input logic w16);
        to_local = d;
        if (big && w16)
        begin
            to_local = {16'h0000, d[7:0], d[15:8]};
        end
        else if (big)
        begin
            to_local = {d[7:0], d[15:8], d[23:16], d[31:24]};
        end
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers, third stage only feeds edge detection
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pd_s_r <= 3'h7; // history high: a pin already high gives no event
            wk_s_r <= 3'h7;
            src_s_r <= 2'h0;
        end
        else
        begin
            pd_s_r <= {pd_s_r[1], pd_s_r[0], powerdown_req_pin};
            wk_s_r <= {wk_s_r[1], wk_s_r[0], wake_normal_pin};
            src_s_r <= {src_s_r[0], pci_clk_from_pin};
        end
    end

    // ------------------------------------------------------------
    // register bank next state
    // ------------------------------------------------------------
    assign acc = bus.req && !ack_r && !err_r;
    assign wr = acc && bus.we;
    assign full_be = (bus.be == 4'hf);

    always_comb
    begin
        mask_nxt = mask_r;
        stat_nxt = stat_r;
        clk_nxt = clk_r;
        bcr1_nxt = bcr1_r;
        bcr2_nxt = bcr2_r;
        bcr3_nxt = bcr3_r;
        area_nxt = area_r;
        rdata_nxt = 32'h00000000;
        ack_nxt = 1'b0;
        err_nxt = 1'b0;
        // soft_reset deliberately leaves every register alone
        if (acc)
        begin
            ack_nxt = 1'b1;
            case (bus.addr)
                `PBC_OFF_MASK:
                begin
                    rdata_nxt = {30'h00000000, mask_r};
                    if (wr)
                    begin
                        mask_nxt = bus.wdata[1:0];
                    end
                end
                `PBC_OFF_STAT:
                begin
                    rdata_nxt = {30'h00000000, stat_r};
                    if (wr)
                    begin
                        stat_nxt = stat_r & ~bus.wdata[1:0];
                    end
                end
                `PBC_OFF_CLK:
                begin
                    rdata_nxt = {30'h00000000, clk_r};
                    if (wr && bus.wdata[`PBC_KEY_HI:`PBC_KEY_LO] == `PBC_CLK_KEY)
                    begin
                        clk_nxt = bus.wdata[1:0];
                    end
                end
                `PBC_OFF_BCR1:
                begin
                    rdata_nxt = bcr1_r;
                    if (wr)
                    begin
                        bcr1_nxt = bus.wdata;
                        bcr1_nxt[`PBC_BIT_MASTER] = 1'b0;
                    end
                end
                `PBC_OFF_BCR2, `PBC_OFF_BCR3:
                begin
                    // only longword access is honoured
                    if (!full_be)
                    begin
                        ack_nxt = 1'b0;
                        err_nxt = 1'b1;
                    end
                    else if (bus.addr == `PBC_OFF_BCR2)
                    begin
                        rdata_nxt = {16'h0000, bcr2_r};
                        if (wr)
                        begin
                            bcr2_nxt = bus.wdata[15:0];
                        end
                    end
                    else
                    begin
                        rdata_nxt = {16'h0000, bcr3_r};
                        if (wr)
                        begin
                            bcr3_nxt = bus.wdata[15:0];
                        end
                    end
                end
                `PBC_OFF_AREA:
                begin
                    rdata_nxt = {25'h0000000, area_r};
                    if (wr && !area_ok(bus.wdata))
                    begin
                        ack_nxt = 1'b0;
                        err_nxt = 1'b1;
                    end
                    else if (wr)
                    begin
                        area_nxt = bus.wdata[`PBC_AREA_BITS-1:0];
                    end
                end
                default:
                begin
                    ack_nxt = 1'b0;
                    err_nxt = 1'b1;
                end
            endcase
        end
        // set wins over a clear in the same cycle
        if (pd_s_r[1] && !pd_s_r[2])
        begin
            stat_nxt[`PBC_BIT_PD] = 1'b1;
        end
        if (wk_s_r[1] && !wk_s_r[2])
        begin
            stat_nxt[`PBC_BIT_WAKE] = 1'b1;
        end
        irq_nxt = |(stat_nxt & mask_nxt);
        pch_nxt = clk_nxt[`PBC_BIT_PCI_HALT] && src_s_r[1];
        lch_nxt = clk_nxt[`PBC_BIT_LOC_HALT];
        fbh_nxt = clk_nxt[`PBC_BIT_LOC_HALT] && !src_s_r[1];
    end

    // power-on reset is the only thing that clears the bank
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            mask_r <= 2'h0;
            stat_r <= 2'h0;
            clk_r <= 2'h0;
            bcr1_r <= `PBC_RST_WORD;
            bcr2_r <= 16'h0000;
            bcr3_r <= 16'h0000;
            area_r <= 7'h00;
            rdata_r <= 32'h00000000;
            ack_r <= 1'b0;
            err_r <= 1'b0;
            irq_r <= 1'b0;
            pch_r <= 1'b0;
            lch_r <= 1'b0;
            fbh_r <= 1'b0;
        end
        else
        begin
            mask_r <= mask_nxt;
            stat_r <= stat_nxt;
            clk_r <= clk_nxt;
            bcr1_r <= bcr1_nxt;
            bcr2_r <= bcr2_nxt;
            bcr3_r <= bcr3_nxt;
            area_r <= area_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
            err_r <= err_nxt;
            irq_r <= irq_nxt;
            pch_r <= pch_nxt;
            lch_r <= lch_nxt;
            fbh_r <= fbh_nxt;
        end
    end

    // ------------------------------------------------------------
    // slave burst engine: one grant, at most 32 bytes, hand back
    // ------------------------------------------------------------
    assign cap_bytes = ({1'b0, xfer_bytes} > `PBC_BURST_MAX) ? `PBC_BURST_MAX : {1'b0, xfer_bytes};
    assign beat_calc = (area_r[`PBC_AREA_WID_HI:`PBC_AREA_WID_LO] == pbc_pkg::PBC_WID_16) ?
                       7'((cap_bytes + 7'h01) >> 1) : 7'((cap_bytes + 7'h03) >> 2);

    always_comb
    begin
        bs_nxt = bs_r;
        beats_nxt = beats_r;
        breq_nxt = breq_r;
        bval_nxt = 1'b0;
        ldata_nxt = ldata_r;
        done_nxt = 1'b0;
        case (bs_r)
            pbc_pkg::PBC_BS_IDLE:
            begin
                // bursts only run on a legal area; a zero length is dropped
                if (xfer_start && beat_calc != 7'h00 && area_ok({25'h0000000, area_r}))
                begin
                    beats_nxt = beat_calc[4:0];
                    breq_nxt = 1'b1;
                    bs_nxt = pbc_pkg::PBC_BS_REQ;
                end
            end
            pbc_pkg::PBC_BS_REQ:
            begin
                if (bus_grant)
                begin
                    bs_nxt = pbc_pkg::PBC_BS_MOVE;
                end
            end
            pbc_pkg::PBC_BS_MOVE:
            begin
                bval_nxt = 1'b1;
                ldata_nxt = to_local(xfer_data, area_r[`PBC_AREA_BIG],
                                     area_r[`PBC_AREA_WID_HI:`PBC_AREA_WID_LO] == pbc_pkg::PBC_WID_16);
                beats_nxt = beats_r - 5'h01;
                if (beats_r == 5'h01)
                begin
                    breq_nxt = 1'b0;
                    bs_nxt = pbc_pkg::PBC_BS_REL;
                end
            end
            pbc_pkg::PBC_BS_REL:
            begin
                done_nxt = 1'b1;
                bs_nxt = pbc_pkg::PBC_BS_IDLE;
            end
            default:
            begin
                bs_nxt = pbc_pkg::PBC_BS_IDLE;
            end
        endcase
        // software reset aborts the burst, never the registers
        if (soft_reset)
        begin
            bs_nxt = pbc_pkg::PBC_BS_IDLE;
            breq_nxt = 1'b0;
            bval_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            bs_r <= pbc_pkg::PBC_BS_IDLE;
            beats_r <= 5'h00;
            breq_r <= 1'b0;
            bval_r <= 1'b0;
            ldata_r <= 32'h00000000;
            done_r <= 1'b0;
        end
        else
        begin
            bs_r <= bs_nxt;
            beats_r <= beats_nxt;
            breq_r <= breq_nxt;
            bval_r <= bval_nxt;
            ldata_r <= ldata_nxt;
            done_r <= done_nxt;
        end
    end

    assign bus.rdata = rdata_r;
    assign bus.ack = ack_r;
    assign bus.err = err_r;
    assign irq = irq_r;
    assign pci_clock_halt = pch_r;
    assign local_clock_halt = lch_r;
    assign feedback_clock_halt = fbh_r;
    assign bus_req = breq_r;
    assign beat_valid = bval_r;
    assign local_data = ldata_r;
    assign xfer_done = done_r;
endmodule
`default_nettype wire

//--- src/pbc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbc_params.svh"
module pbc_host
(
    input wire logic clock,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    pbc_if.ctl bus
);
    // ------------------------------------------------------------
    // wishbone window onto the device end, plus own status word
    // ------------------------------------------------------------
    pbc_pkg::pbc_host_e hs_r, hs_nxt;
    logic req_r, req_nxt;
    logic we_r, we_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] be_r, be_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic ack_r, ack_nxt;
    logic refused_r, refused_nxt;
    logic start;
    logic bad_width;
    logic bad_area;
    logic [2:0] area_t;

    assign start = wb_cyc_i && wb_stb_i && !ack_r;
    assign area_t = wb_dat_i[`PBC_AREA_TYPE_HI:`PBC_AREA_TYPE_LO];
    // partial access to the 16-bit controls is caught here first
    assign bad_width = (wb_adr_i == `PBC_OFF_BCR2 || wb_adr_i == `PBC_OFF_BCR3) && wb_sel_i != 4'hf;
    // refuse areas that must never carry pci data
    assign bad_area = wb_we_i && wb_adr_i == `PBC_OFF_AREA &&
                      (area_t == pbc_pkg::PBC_MEM_BROM || area_t == pbc_pkg::PBC_MEM_BCSRAM ||
                       area_t == pbc_pkg::PBC_MEM_CARD);

    always_comb
    begin
        hs_nxt = hs_r;
        req_nxt = req_r;
        we_nxt = we_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        be_nxt = be_r;
        dat_nxt = dat_r;
        ack_nxt = 1'b0;
        refused_nxt = refused_r;
        case (hs_r)
            pbc_pkg::PBC_HS_IDLE:
            begin
                if (start && wb_adr_i == `PBC_OFF_HSTAT)
                begin
                    dat_nxt = {30'h00000000, req_r, refused_r};
                    if (wb_we_i && wb_dat_i[0])
                    begin
                        refused_nxt = 1'b0;
                    end
                    ack_nxt = 1'b1;
                    hs_nxt = pbc_pkg::PBC_HS_DONE;
                end
                else if (start && (wb_adr_i >= `PBC_WIN_TOP || wb_adr_i[1:0] != 2'h0 || bad_width || bad_area))
                begin
                    // unmapped or refused: answer at once with zero data
                    dat_nxt = 32'h00000000;
                    refused_nxt = 1'b1;
                    ack_nxt = 1'b1;
                    hs_nxt = pbc_pkg::PBC_HS_DONE;
                end
                else if (start)
                begin
                    req_nxt = 1'b1;
                    we_nxt = wb_we_i;
                    addr_nxt = wb_adr_i;
                    // software is expected to zero reserved bits itself
                    wdata_nxt = wb_dat_i;
                    be_nxt = wb_sel_i;
                    hs_nxt = pbc_pkg::PBC_HS_WAIT;
                end
            end
            pbc_pkg::PBC_HS_WAIT:
            begin
                if (bus.ack || bus.err)
                begin
                    req_nxt = 1'b0;
                    dat_nxt = bus.err ? 32'h00000000 : bus.rdata;
                    refused_nxt = refused_r | bus.err;
                    ack_nxt = 1'b1;
                    hs_nxt = pbc_pkg::PBC_HS_DONE;
                end
            end
            pbc_pkg::PBC_HS_DONE:
            begin
                // one idle cycle so the master sees ack drop
                hs_nxt = pbc_pkg::PBC_HS_IDLE;
            end
            default:
            begin
                hs_nxt = pbc_pkg::PBC_HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            hs_r <= pbc_pkg::PBC_HS_IDLE;
            req_r <= 1'b0;
            we_r <= 1'b0;
            addr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            be_r <= 4'h0;
            dat_r <= 32'h00000000;
            ack_r <= 1'b0;
            refused_r <= 1'b0;
        end
        else
        begin
            hs_r <= hs_nxt;
            req_r <= req_nxt;
            we_r <= we_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            be_r <= be_nxt;
            dat_r <= dat_nxt;
            ack_r <= ack_nxt;
            refused_r <= refused_nxt;
        end
    end

    // refresh and sdram mode setup stay with the main controller
    assign bus.req = req_r;
    assign bus.we = we_r;
    assign bus.addr = addr_r;
    assign bus.wdata = wdata_r;
    assign bus.be = be_r;
    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;
endmodule
`default_nettype wire

//--- verif/pbc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// device bus checks
// ----
module pbc_assertions
(
    input wire logic clock,
    input wire logic rst,
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [3:0] be,
    input wire logic [31:0] rdata,
    input wire logic ack,
    input wire logic err
);
    logic ok;
    // legal area: four types, 16 or 32 wide, sdram 32 only, no ras-down
    assign ok = wdata[2:0] < 3'h4 && !wdata[5] && (wdata[4:3] == 2'h2 || (wdata[4:3] == 2'h1 && wdata[2:0] != 3'h2));
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // pending request, and the answer to a read of one offset
    sequence s_take; req && !ack && !err; endsequence
    sequence s_rd(a); ack && !we && addr == a; endsequence
    // a taken request to one of the 16-bit controls
    sequence s_ctl; s_take ##0 (addr == 8'h10 || addr == 8'h14); endsequence
    answer_a: assert property (s_take |=> ack != err) else $error("no single answer");
    ack_pulse_a: assert property (ack |=> !ack) else $error("ack too long");
    req_hold_a: assert property (s_take |=> $stable(addr) && $stable(wdata) && $stable(we))
        else $error("moved");
    mask_zero_a: assert property (s_rd(8'h00) |-> rdata[31:2] == 30'h0) else $error("mask reserved set");
    stat_zero_a: assert property (s_rd(8'h04) |-> rdata[31:2] == 30'h0) else $error("status reserved set");
    clk_zero_a: assert property (s_rd(8'h08) |-> rdata[31:2] == 30'h0) else $error("clock reserved set");
    slave_flag_a: assert property (s_rd(8'h0c) |-> !rdata[30]) else $error("master flag set");
    ctrl_low_a: assert property ((s_rd(8'h10) or s_rd(8'h14)) |-> rdata[31:16] == 16'h0)
        else $error("upper set");
    be_err_a: assert property (s_ctl |=> err == (be != 4'hf)) else $error("width refusal wrong");
    area_a: assert property (s_take ##0 (we && addr == 8'h18) |=> err == !ok)
        else $error("area check wrong");
endmodule
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// bench top
// ----
module tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, srst = 1'b0, pd = 1'b0, wk = 1'b0, src = 1'b1, xs = 1'b0, gnt = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [5:0] xb = 6'h0;
    logic [31:0] dat = 32'h0, xd = 32'h0, rd, wbo, ldat;
    logic ack, irq, pch, lch, fch, breq, bv, done;
    logic [31:0] good [4] = '{32'h10, 32'h12, 32'h13, 32'h49};
    logic [31:0] bad [7] = '{32'h00, 32'h0a, 32'h14, 32'h15, 32'h16, 32'h17, 32'h32};
    int bad_count = 0, n_checks = 0;
    pbc_if bus();
    pbc_host i_pbc_host(.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(wbo), .wb_ack_o(ack), .bus(bus));
    pbc_dev i_pbc_dev(.clock(clock), .rst(rst), .bus(bus), .soft_reset(srst), .powerdown_req_pin(pd),
        .wake_normal_pin(wk), .pci_clk_from_pin(src), .xfer_start(xs), .xfer_bytes(xb), .xfer_data(xd),
        .bus_grant(gnt), .irq(irq), .pci_clock_halt(pch), .local_clock_halt(lch), .feedback_clock_halt(fch),
        .bus_req(breq), .beat_valid(bv), .local_data(ldat), .xfer_done(done));
    pbc_assertions i_pbc_assertions(.clock(clock), .rst(rst), .req(bus.req), .we(bus.we), .addr(bus.addr),
        .wdata(bus.wdata), .be(bus.be), .rdata(bus.rdata), .ack(bus.ack), .err(bus.err));
    // 250 MHz
    always #2 clock = ~clock;
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %0t got %h want %h", $time, got, exp);
        end
    endtask
    // a wait that runs out ends the run
    task automatic hang();
        bad_count++;
        $display("Error %0t wait ran out", $time);
        report_and_stop();
    endtask
    // classic cycle: held until ack is seen at an edge, data taken there
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int i;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        for (i = 0; i < 50 && ack !== 1'b1; i++)
            @(posedge clock);
        if (ack !== 1'b1)
            hang();
        rd = wbo;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hf);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, 4'hf);
        chk(rd, e);
    endtask
    // grant held back a while, so the request must wait for it
    task automatic burst(input logic [5:0] b, input logic [31:0] e, input int beats);
        int i;
        int n;
        n = 0;
        @(posedge clock);
        xb <= b;
        xd <= 32'h11223344;
        xs <= 1'b1;
        @(posedge clock);
        xs <= 1'b0;
        repeat (4) @(posedge clock);
        chk(32'({breq, bv}), 32'h2);
        gnt <= 1'b1;
        for (i = 0; i < 60 && done !== 1'b1; i++)
        begin
            @(posedge clock);
            if (bv === 1'b1)
            begin
                n++;
                chk(ldat, e);
            end
        end
        if (done !== 1'b1)
            hang();
        gnt <= 1'b0;
        chk(n, beats);
        chk(32'(breq), 32'h0);
    endtask
    // main sequence
    initial
    begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        rc(8'h00, 32'h0);
        rc(8'h08, 32'h0);
        wr(8'h08, 32'h00000003);
        rc(8'h08, 32'h0);
        wr(8'h08, 32'ha5000003);
        rc(8'h08, 32'h3);
        chk(32'({pch, lch, fch}), 32'h6);
        src <= 1'b0;
        repeat (6) @(posedge clock);
        chk(32'({pch, lch, fch}), 32'h3);
        wr(8'h00, 32'h1);
        pd <= 1'b1;
        repeat (8) @(posedge clock);
        pd <= 1'b0;
        rc(8'h04, 32'h2);
        chk(32'(irq), 32'h0);
        wr(8'h00, 32'h3);
        repeat (2) @(posedge clock);
        chk(32'(irq), 32'h1);
        wr(8'h04, 32'h1);
        rc(8'h04, 32'h2);
        wr(8'h04, 32'h2);
        rc(8'h04, 32'h0);
        chk(32'(irq), 32'h0);
        wr(8'h00, 32'h2);
        wk <= 1'b1;
        repeat (8) @(posedge clock);
        wk <= 1'b0;
        rc(8'h04, 32'h1);
        chk(32'(irq), 32'h0);
        wr(8'h00, 32'h1);
        repeat (2) @(posedge clock);
        chk(32'(irq), 32'h1);
        srst <= 1'b1;
        @(posedge clock);
        srst <= 1'b0;
        rc(8'h00, 32'h1);
        rc(8'h08, 32'h3);
        wr(8'h0c, 32'h40000005);
        rc(8'h0c, 32'h5);
        wr(8'h10, 32'h1234abcd);
        rc(8'h10, 32'habcd);
        wb(1'b1, 8'h14, 32'h5555, 4'h3);
        rc(8'h14, 32'h0);
        wb(1'b0, 8'h40, 32'h0, 4'hf);
        chk(rd & 32'h1, 32'h1);
        foreach (good[i])
        begin
            wr(8'h18, good[i]);
            rc(8'h18, good[i]);
        end
        foreach (bad[i])
        begin
            wr(8'h18, bad[i]);
            rc(8'h18, 32'h49);
        end
        rc(8'h10, 32'habcd);
        wr(8'h18, 32'h10);
        burst(6'h28, 32'h11223344, 8);
        wr(8'h18, 32'h50);
        burst(6'h04, 32'h44332211, 1);
        // 16-bit big endian: low half swapped, cap counted in half-words
        wr(8'h18, 32'h49);
        burst(6'h28, 32'h00004433, 16);
        // software reset drops a pending request but keeps the bank
        @(posedge clock);
        xs <= 1'b1;
        @(posedge clock);
        xs <= 1'b0;
        srst <= 1'b1;
        @(posedge clock);
        srst <= 1'b0;
        chk(32'(breq), 32'h1);
        @(posedge clock);
        chk(32'(breq), 32'h0);
        rc(8'h18, 32'h49);
        report_and_stop();
    end
endmodule
`default_nettype wire
